// ---- sdp_pkg.sv ----
package sdp_pkg;
    // select bit positions in the system-io configuration word
    localparam int SEL_WIDTH = 13;
    localparam int SEL_TDI = 4;
    localparam int SEL_TDO = 5;
    localparam int SEL_TMS = 6;
    localparam int SEL_TCK = 7;
    localparam int SEL_DM = 10;
    localparam int SEL_DP = 11;
    localparam int SEL_ERASE = 12;
    // reset value: every shared pin in its system function
    localparam logic [12:0] SEL_RESET = 13'h0000;
    // port controller size
    localparam int PORT_LINES = 32;
    // peripheral function encodings
    localparam logic [1:0] FUNC_A = 2'h0;
    localparam logic [1:0] FUNC_B = 2'h1;
    localparam logic [1:0] FUNC_C = 2'h2;
    // switch sequence: at least 50 tms-high clocks, then the 16-bit key
    localparam int SW_HIGH_MIN = 50;
    localparam logic [15:0] SW_KEY = 16'he79e;
    localparam int SW_KEY_BITS = 16;
    // debug protocol states
    typedef enum logic [1:0] {
        SDP_FOUR_WIRE,
        SDP_KEY,
        SDP_SERIAL_WIRE
    } sdp_proto_t;
endpackage

// ---- sdp_pin_select.sv ----
// Function
// - select bits 12, 10-11, 4-7 per pin
// - debug pins in debug mode after reset
// - debug pins switch only via select bits
// - pad settings apply in either mode
// - boundary scan while select pin high
// - four-wire protocol active after reset
// - trace output only in serial-wire mode
// - 32 lines, each function A/B/C
// - system function used at startup
`timescale 1ns/10ps
module sdp_pin_select #(
    parameter int LINES = sdp_pkg::PORT_LINES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [12:0] sysio_sel,
    input wire logic [2*LINES-1:0] periph_func,
    input wire logic [2:0] pad_cfg,
    input wire logic boundary_scan_select,
    input wire logic dbg_clk_pin,
    input wire logic dbg_mode_data_pin,
    input wire logic erase_pin,
    input wire logic trace_data,
    input wire logic tdo_data,
    output logic [12:0] port_owned,
    output logic [2*LINES-1:0] line_func,
    output logic [2:0] pad_cfg_applied,
    output logic boundary_scan_en,
    output logic four_wire_debug_mode,
    output logic serial_wire_debug_mode,
    output logic erase_request,
    output logic async_trace_output,
    output logic tdo_pin_out
);
    // two-flop synchronisers for pins
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic sclk;
    logic stms;
    logic sjsel;
    logic serase;
    logic sclk_d_reg;
    logic sclk_rise;
    // protocol switch detector
    sdp_pkg::sdp_proto_t proto_reg;
    logic [6:0] high_cnt_reg;
    logic [15:0] key_shift_reg;
    logic [4:0] key_cnt_reg;

    // synchronise pin inputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
        end else begin
            meta_reg <= {erase_pin, boundary_scan_select,
                         dbg_mode_data_pin, dbg_clk_pin};
            sync_reg <= meta_reg;
        end
    end
    assign sclk = sync_reg[0];
    assign stms = sync_reg[1];
    assign sjsel = sync_reg[2];
    assign serase = sync_reg[3];

    // debug clock edge detector on synchronised value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk;
        end
    end
    assign sclk_rise = sclk & ~sclk_d_reg;

    // select register, owned by port controller when bit set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_owned <= sdp_pkg::SEL_RESET;
        end else begin
            port_owned <= sysio_sel;
        end
    end

    // peripheral function per line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_func <= '0;
        end else begin
            // one of A, B or C per line
            for (int i = 0; i < LINES; i++) begin
                if (periph_func[2*i +: 2] == 2'h3) begin
                    line_func[2*i +: 2] <= sdp_pkg::FUNC_A;
                end else begin
                    line_func[2*i +: 2] <= periph_func[2*i +: 2];
                end
            end
        end
    end

    // pad settings pass regardless of mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pad_cfg_applied <= 3'h0;
        end else begin
            pad_cfg_applied <= pad_cfg;
        end
    end

    // boundary scan enable and erase request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boundary_scan_en <= 1'b0;
            erase_request <= 1'b0;
        end else begin
            boundary_scan_en <= sjsel;
            // erase only while pin in system mode and high
            erase_request <= serase & ~port_owned[sdp_pkg::SEL_ERASE];
        end
    end

    // protocol switch state machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            proto_reg <= sdp_pkg::SDP_FOUR_WIRE;
            high_cnt_reg <= 7'h00;
            key_shift_reg <= 16'h0000;
            key_cnt_reg <= 5'h00;
        end else if (sclk_rise) begin
            case (proto_reg)
                sdp_pkg::SDP_FOUR_WIRE: begin
                    if (stms) begin
                        if (high_cnt_reg < 7'(sdp_pkg::SW_HIGH_MIN)) begin
                            high_cnt_reg <= high_cnt_reg + 7'h01;
                        end
                    end else if (high_cnt_reg >= 7'(sdp_pkg::SW_HIGH_MIN)) begin
                        proto_reg <= sdp_pkg::SDP_KEY;
                        key_shift_reg <= {1'b0, 15'h0000};
                        key_cnt_reg <= 5'h01;
                    end else begin
                        high_cnt_reg <= 7'h00;
                    end
                end
                sdp_pkg::SDP_KEY: begin
                    // key shifted in lsb first
                    key_shift_reg <= {stms, key_shift_reg[15:1]};
                    key_cnt_reg <= key_cnt_reg + 5'h01;
                    if (key_cnt_reg == 5'(sdp_pkg::SW_KEY_BITS - 1)) begin
                        high_cnt_reg <= 7'h00;
                        if ({stms, key_shift_reg[15:1]} == sdp_pkg::SW_KEY) begin
                            proto_reg <= sdp_pkg::SDP_SERIAL_WIRE;
                        end else begin
                            proto_reg <= sdp_pkg::SDP_FOUR_WIRE;
                        end
                    end
                end
                sdp_pkg::SDP_SERIAL_WIRE: begin
                    proto_reg <= sdp_pkg::SDP_SERIAL_WIRE;
                end
                default: begin
                    proto_reg <= sdp_pkg::SDP_FOUR_WIRE;
                end
            endcase
        end
    end

    // protocol outputs and tdo/trace mux
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            four_wire_debug_mode <= 1'b1;
            serial_wire_debug_mode <= 1'b0;
            async_trace_output <= 1'b0;
            tdo_pin_out <= 1'b0;
        end else begin
            four_wire_debug_mode <= proto_reg != sdp_pkg::SDP_SERIAL_WIRE;
            serial_wire_debug_mode <= proto_reg == sdp_pkg::SDP_SERIAL_WIRE;
            async_trace_output <= (proto_reg == sdp_pkg::SDP_SERIAL_WIRE) & trace_data;
            tdo_pin_out <= (proto_reg == sdp_pkg::SDP_SERIAL_WIRE) ? trace_data : tdo_data;
        end
    end

    // assertions
    // select follows input
    // first edge after a reset still shows the reset value, so skip it
    a_sel_follow: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> port_owned == $past(sysio_sel))
        else $error("select register did not follow input");
    a_dbg_reset: assert property (@(posedge clk)
        $fell(rst) |-> port_owned[7:4] == 4'h0)
        else $error("debug pins not in debug mode after reset");
    a_scan_follow: assert property (@(posedge clk) disable iff (rst)
        $rose(boundary_scan_select) |-> ##3 boundary_scan_en)
        else $error("boundary scan not enabled");
    a_scan_drop: assert property (@(posedge clk) disable iff (rst)
        $fell(boundary_scan_select) |-> ##3 !boundary_scan_en)
        else $error("boundary scan not disabled");
    a_mode_excl: assert property (@(posedge clk) disable iff (rst)
        four_wire_debug_mode != serial_wire_debug_mode)
        else $error("debug modes not exclusive");
    a_trace_gate: assert property (@(posedge clk) disable iff (rst)
        four_wire_debug_mode |-> !async_trace_output)
        else $error("trace active in four-wire mode");
    a_func_legal: assert property (@(posedge clk) disable iff (rst)
        line_func[1:0] != 2'h3)
        else $error("illegal peripheral function");
    a_pad_pass: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> pad_cfg_applied == $past(pad_cfg))
        else $error("pad settings not applied");
    a_erase_gate: assert property (@(posedge clk) disable iff (rst)
        port_owned[12] |=> !erase_request)
        else $error("erase while pin owned by port");
    a_sw_switch: assert property (@(posedge clk) disable iff (rst)
        $rose(serial_wire_debug_mode) |-> $past(proto_reg, 2) == sdp_pkg::SDP_KEY)
        else $error("serial wire without sequence");
    c_sw_entered: cover property (@(posedge clk) disable iff (rst) $rose(serial_wire_debug_mode));
    c_scan_on: cover property (@(posedge clk) disable iff (rst) $rose(boundary_scan_en));
    c_dbg_port: cover property (@(posedge clk) disable iff (rst) port_owned[7:4] == 4'hf);
endmodule

// ---- sdp_probe_model.sv ----
`timescale 1ns/10ps
// debug probe host driving the clock and mode/data pins
module sdp_probe_model (
    input wire logic clk,
    output logic tck,
    output logic tms
);
    // one probe clock period, each level held four system clocks
    task automatic tick(input logic b);
        tms = b;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        repeat (4) @(negedge clk);
        tck = 1'b0;
    endtask
    // line reset with mode pin high, then key lsb first
    task automatic send(input logic [15:0] key);
        for (int i = 0; i < 56; i++) tick(1'b1);
        for (int i = 0; i < 16; i++) tick(key[i]);
        // released data line shows the inverse of its last level
        tms = ~key[15];
    endtask
    // clock stands still low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b0;
    end
endmodule

// ---- sdp_pin_select_test.sv ----
`timescale 1ns/10ps
module sdp_pin_select_test;
    logic clk, rst, bscan, trace, tdo, tck, tms, exp_sw, erase;
    logic [12:0] sel, owned;
    logic [63:0] pf, lf;
    logic [2:0] pad, pad_app;
    logic scan_en, four_w, serial_w, erase_req, trace_out, tdo_out;
    logic [31:0] seed;
    int fail_count;
    int tests_run;
    sdp_probe_model probe (.clk(clk), .tck(tck), .tms(tms));
    sdp_pin_select dut (.clk(clk), .rst(rst), .sysio_sel(sel), .periph_func(pf),
        .pad_cfg(pad), .boundary_scan_select(bscan), .dbg_clk_pin(tck),
        .dbg_mode_data_pin(tms), .erase_pin(erase), .trace_data(trace), .tdo_data(tdo),
        .port_owned(owned),
        .line_func(lf), .pad_cfg_applied(pad_app), .boundary_scan_en(scan_en),
        .four_wire_debug_mode(four_w), .serial_wire_debug_mode(serial_w),
        .erase_request(erase_req), .async_trace_output(trace_out), .tdo_pin_out(tdo_out));
    // free-running system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // unused code 3 reads as function a
    function automatic logic [63:0] exp_func(input logic [63:0] f);
        logic [63:0] e;
        e = f;
        for (int i = 0; i < 32; i++) if (f[2*i +: 2] == 2'h3) e[2*i +: 2] = sdp_pkg::FUNC_A;
        return e;
    endfunction
    // compares one value
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // drives one input set, then checks every output except the two debug mode flags
    task automatic apply(input logic [12:0] s, input logic [63:0] f, input logic [2:0] p,
        input logic b);
        logic [31:0] r;
        r = rnd();
        @(negedge clk);
        sel = s;
        pf = f;
        pad = p;
        bscan = b;
        trace = r[3];
        tdo = r[7];
        erase = r[11];
        @(negedge clk);
        check("port_owned", 64'(s), 64'(owned));
        repeat (3) @(negedge clk);
        check("line_func", exp_func(f), lf);
        check("pad", 64'(p), 64'(pad_app));
        check("scan_en", 64'(b), 64'(scan_en));
        check("tdo_pin", 64'(exp_sw ? trace : tdo), 64'(tdo_out));
        check("trace_out", 64'(exp_sw & trace), 64'(trace_out));
        check("erase", 64'(r[11] & ~s[sdp_pkg::SEL_ERASE]), 64'(erase_req));
    endtask
    // corner words then random rounds
    task automatic rounds(input string name);
        apply(13'h1fff, 64'hffffffffffffffff, 3'h7, 1'b1);
        apply(13'h1cf0, 64'haaaaaaaa55555555, 3'h5, 1'b0);
        apply(13'h0000, 64'h0, 3'h0, 1'b0);
        for (int i = 0; i < 20; i++)
            apply(13'(rnd()), {rnd(), rnd()}, 3'(rnd()), rnd() > 32'h7fffffff);
        $display("test %s done", name);
    endtask
    // closing report
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
    // main sequence
    initial begin
        {fail_count, tests_run} = 0;
        seed = 32'h0000000f;
        {rst, sel, pf, pad, bscan, trace, tdo, exp_sw} = {1'b1, 84'h0};
        erase = 1'b0;
        repeat (12) @(negedge clk);
        check("owned_rst", 64'h0, 64'(owned));
        check("dbg_rst", 64'h0, 64'(owned[7:4]));
        check("four_rst", 64'h2, 64'({four_w, serial_w}));
        rst = 1'b0;
        check("scan_rst", 64'h0, 64'(scan_en));
        $display("test reset done");
        rounds("four_wire");
        probe.send(16'h1234);
        repeat (6) @(negedge clk);
        check("bad_key", 64'h2, 64'({four_w, serial_w}));
        probe.send(sdp_pkg::SW_KEY);
        repeat (6) @(negedge clk);
        check("good_key", 64'h1, 64'({four_w, serial_w}));
        $display("test key_switch done");
        exp_sw = 1'b1;
        rounds("serial_wire");
        rst = 1'b1;
        @(negedge clk);
        check("rerst", 64'h2, 64'({four_w, serial_w}));
        rst = 1'b0;
        exp_sw = 1'b0;
        repeat (2) @(negedge clk);
        check("rerst_owned", 64'(sel), 64'(owned));
        check("rerst_mode", 64'h2, 64'({four_w, serial_w}));
        $display("test second_reset done");
        print_verdict();
    end
endmodule
